/* dv/periph_irq_flag_enable_regs_test.sv */
`timescale 1ns/1ns
module periph_irq_flag_enable_regs_test
  import pif_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        i_clock;
  logic        i_rst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] small_rd;
  logic [7:0]  small_req4;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        nv_done;
  logic [2:0]  cmp_ev;
  logic [7:0]  src3;
  logic [7:0]  src4;
  logic [7:0]  req6;
  logic [7:0]  req3;
  logic [7:0]  req4;
  logic        irq;
  int          miscompares;
  int          n_checks;

  always #25 i_clock = ~i_clock;

  pif_irq_regs dut (
    .i_clock(i_clock), .i_rst(i_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .i_nv_write_done(nv_done), .i_comparator_event(cmp_ev), .i_src_three_req(src3),
    .i_src_four_req(src4), .o_req_six(req6), .o_req_three(req3), .o_req_four(req4), .o_irq(irq));

  // Small memory variant on the same bus, watched for its readback and enable-four requests only
  pif_irq_regs #(.SMALL_PROGRAM_MEMORY(1'b1)) dut_small (
    .i_clock(i_clock), .i_rst(i_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(small_rd), .avs_waitrequest(), .avs_response(),
    .i_nv_write_done(nv_done), .i_comparator_event(cmp_ev), .i_src_three_req(src3),
    .i_src_four_req(src4), .o_req_six(), .o_req_three(), .o_req_four(small_req4), .o_irq());

  pif_src_model src (
    .i_clock(i_clock), .o_nv_write_done(nv_done), .o_comparator_event(cmp_ev),
    .o_src_three_req(src3), .o_src_four_req(src4));

  // ---------------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low; one idle edge after release
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    @(posedge i_clock);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge i_clock);
    end
    q = avs_readdata;
    r = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, a, d, q, r);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, a, 32'h0, q, r);
    chk(q, exp);
    chk({30'h0, r}, 32'h0);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rd(6'h00, 32'h0);
    rd(6'h04, 32'h0);
    rd(6'h08, 32'h0);
    rd(6'h14, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_flags;
    fork
      src.nv_write(10);
      rd(6'h00, 32'h0);
    join
    repeat (3) @(posedge i_clock);
    rd(6'h00, 32'h10);
    chk({24'h0, req6}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(6'h14, 32'hff);
    rd(6'h14, 32'h17);
    chk({24'h0, req6}, 32'h10);
    chk({31'h0, irq}, 32'h1);
    src.pulse_cmp(3'h7);
    repeat (3) @(posedge i_clock);
    rd(6'h00, 32'h17);
    wr(6'h00, 32'hff);
    rd(6'h00, 32'h17);
    wr(6'h00, 32'h13);
    rd(6'h00, 32'h13);
    rd(6'h00, 32'h13);
    rd(6'h0c, 32'h13);
    wr(6'h10, 32'h13);
    rd(6'h00, 32'h0);
    repeat (2) @(posedge i_clock);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_enables;
    src.set_levels(8'hff, 8'hff);
    repeat (3) @(posedge i_clock);
    chk({16'h0, req3, req4}, 32'h0);
    wr(6'h04, 32'h8f);
    rd(6'h04, 32'h8f);
    repeat (3) @(posedge i_clock);
    chk({24'h0, req3}, 32'h8f);
    wr(6'h04, 32'hcf);
    repeat (3) @(posedge i_clock);
    chk({24'h0, req3}, 32'h8f);
    wr(6'h18, 32'h1);
    repeat (3) @(posedge i_clock);
    chk({24'h0, req3}, 32'hcf);
    chk({31'h0, irq}, 32'h1);
    wr(6'h08, 32'hff);
    rd(6'h08, 32'hff);
    chk(small_rd, 32'h3f);
    repeat (3) @(posedge i_clock);
    chk({24'h0, req4}, 32'hff);
    chk({24'h0, small_req4}, 32'h3f);
    src.set_levels(8'h00, 8'h00);
    repeat (3) @(posedge i_clock);
    chk({15'h0, req3, req4, irq}, 32'h0);
  endtask

  // Unmapped place answers with zero data and the error code
  task automatic t_unmapped;
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, 6'h20, 32'h0, q, r);
    chk(q, 32'h0);
    chk({30'h0, r}, 32'h2);
    // A write without byte lane 0 is refused
    avs_byteenable <= 4'he;
    wr(6'h04, 32'h00);
    avs_byteenable <= 4'hf;
    rd(6'h04, 32'hcf);
  endtask

  // Reset in mid-run with state set must bring every register back to zero
  task automatic t_mid_reset;
    src.pulse_cmp(3'h1);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    rd(6'h00, 32'h0);
    rd(6'h04, 32'h0);
    rd(6'h08, 32'h0);
    rd(6'h14, 32'h0);
    rd(6'h18, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    i_clock       = 1'b0;
    i_rst         = 1'b1;
    avs_address   = 6'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    miscompares   = 0;
    n_checks      = 0;
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_reset();
    t_flags();
    t_enables();
    t_unmapped();
    t_mid_reset();
    complete_run();
  end

  initial begin
    #(50 * 5000);
    miscompares++;
    complete_run();
  end
endmodule

/* dv/pif_src_model.sv */
`timescale 1ns/1ns
module pif_src_model (
  input  wire logic       i_clock,            // Core clock
  output logic            o_nv_write_done,    // Write completion pulse
  output logic      [2:0] o_comparator_event, // Comparator 3..1 pulses
  output logic      [7:0] o_src_three_req,    // Enable-three source levels
  output logic      [7:0] o_src_four_req      // Capture 10..3 levels
);
  // ---------------------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------------------
  initial begin
    o_nv_write_done    = 1'b0;
    o_comparator_event = 3'h0;
    o_src_three_req    = 8'h00;
    o_src_four_req     = 8'h00;
  end

  // Completion only after the whole write time, so the flag can be seen low meanwhile
  task automatic nv_write(input int cycles);
    repeat (cycles) @(posedge i_clock);
    o_nv_write_done <= 1'b1;
    @(posedge i_clock);
    o_nv_write_done <= 1'b0;
  endtask

  task automatic pulse_cmp(input logic [2:0] ev);
    @(posedge i_clock);
    o_comparator_event <= ev;
    @(posedge i_clock);
    o_comparator_event <= 3'h0;
  endtask

  task automatic set_levels(input logic [7:0] three, input logic [7:0] four);
    @(posedge i_clock);
    o_src_three_req <= three;
    o_src_four_req  <= four;
  endtask
endmodule

/* verilog/pif_irq_regs.sv */
`timescale 1ns/1ns
// How it works
// - Nonvolatile write completion sets flag bit 4; it holds until software clears it.
// - Bit 4 reads zero while writing or before any write since clear.
// - Comparator 3,2,1 events set flag bits 2,1,0; held until written zero.
// - Flag bits 7..5 and 3 read zero; writes to them are ignored.
// - All implemented flag and enable bits are zero after reset.
// - Enable-three bits gate timer5 gate, LCD, serial2 rx/tx, charge time, capture2/1, rtc.
// - LCD enable counts only with type-B waveform in non-static mode.
// - Enable-four bits 7..0 gate capture units 10 down to 3.
// - On 32 Kbyte variants, capture 10 and 9 enables read zero.
module pif_irq_regs
  import pif_pkg::*;
#(
  parameter bit SMALL_PROGRAM_MEMORY = 1'b0  // 32 Kbyte variant
)(
  input  wire logic        i_clock,             // 20 MHz core clock
  input  wire logic        i_rst,               // Sync reset, active high
  input  wire logic [5:0]  avs_address,         // Byte address
  input  wire logic        avs_read,            // Read strobe
  input  wire logic        avs_write,           // Write strobe
  input  wire logic [31:0] avs_writedata,       // Write data
  input  wire logic [3:0]  avs_byteenable,      // Byte lanes
  output logic      [31:0] avs_readdata,        // Read data
  output logic             avs_waitrequest,     // Stall
  output logic      [1:0]  avs_response,        // 00 ok, 10 slave error
  input  wire logic        i_nv_write_done,     // Pulse: write completed
  input  wire logic [2:0]  i_comparator_event,  // Pulses, comparator 3..1
  input  wire logic [7:0]  i_src_three_req,     // Source requests for enable-three
  input  wire logic [7:0]  i_src_four_req,      // Capture 10..3 requests
  output logic      [7:0]  o_req_six,           // Forwarded flag-six requests
  output logic      [7:0]  o_req_three,         // Forwarded enable-three requests
  output logic      [7:0]  o_req_four,          // Forwarded enable-four requests
  output logic             o_irq                // Level interrupt
);
  // ---------------------------------------------------------------------------
  // Bus handshake: two wait cycles, then answer from a register
  // ---------------------------------------------------------------------------
  pif_bus_state_t st_reg, st_next;
  logic [31:0]    rd_word;
  logic           rd_load;
  logic [1:0]     resp_reg, resp_next;
  logic           wait_reg, wait_next;
  logic           mapped;
  logic           do_write;
  logic           lane0;

  assign lane0  = avs_byteenable[0];
  assign mapped = (avs_address[1:0] == 2'b00) && (avs_address <= OFF_LCD_CFG_W);

  always_comb begin
    st_next   = st_reg;
    wait_next = 1'b1;
    resp_next = resp_reg;
    rd_load   = 1'b0;
    do_write  = 1'b0;
    case (st_reg)
      ST_IDLE: begin
        if (avs_read || avs_write) begin
          st_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        st_next   = ST_RESP;
        wait_next = 1'b0;
        rd_load   = avs_read;
        resp_next = mapped ? 2'b00 : 2'b10;
      end
      // Write lands on the edge where the master sees waitrequest low
      ST_RESP: begin
        st_next  = ST_IDLE;
        do_write = avs_write && mapped && lane0;
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_reg   <= ST_IDLE;
      wait_reg <= 1'b1;
      resp_reg <= 2'b00;
    end else begin
      st_reg   <= st_next;
      wait_reg <= wait_next;
      resp_reg <= resp_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_response    = resp_reg;

  // ---------------------------------------------------------------------------
  // Flags and enables
  // ---------------------------------------------------------------------------
  logic [7:0] flags_reg, flags_next;
  logic [7:0] en3_reg, en3_next;
  logic [7:0] en4_reg, en4_next;
  logic [7:0] en6_reg, en6_next;
  logic       lcd_typeb_reg, lcd_typeb_next;
  logic [7:0] wbyte;
  logic [7:0] set_six;
  logic [7:0] en4_mask;
  pif_events_t ev_in;

  assign wbyte    = avs_writedata[7:0];
  assign en4_mask = SMALL_PROGRAM_MEMORY ? ENABLE_FOUR_SMALL_MASK : 8'hff;
  assign ev_in    = {i_nv_write_done, i_comparator_event};
  assign set_six  = {3'b000, ev_in.nv_write_done, 1'b0, ev_in.comparator};

  // A write and an event in one cycle: the event wins, nothing is lost.
  always_comb begin
    flags_next     = flags_reg;
    en3_next       = en3_reg;
    en4_next       = en4_reg;
    en6_next       = en6_reg;
    lcd_typeb_next = lcd_typeb_reg;
    if (do_write) begin
      case (avs_address)
        OFF_FLAGS_SIX: flags_next = wbyte & FLAGS_SIX_MASK;
        OFF_ENABLE_THREE: en3_next = wbyte;
        OFF_ENABLE_FOUR: en4_next = wbyte & en4_mask;
        OFF_IRQ_CLR_W: flags_next = flags_reg & ~(wbyte & FLAGS_SIX_MASK);
        OFF_IRQ_EN_W: en6_next = wbyte & FLAGS_SIX_MASK;
        OFF_LCD_CFG_W: lcd_typeb_next = wbyte[0];
        default: flags_next = flags_reg;
      endcase
    end
    flags_next = (flags_next | set_six) & FLAGS_SIX_MASK;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flags_reg     <= RST_FLAGS;
      en3_reg       <= RST_ENABLE;
      en4_reg       <= RST_ENABLE;
      en6_reg       <= RST_ENABLE;
      lcd_typeb_reg <= 1'b0;
    end else begin
      flags_reg     <= flags_next;
      en3_reg       <= en3_next;
      en4_reg       <= en4_next;
      en6_reg       <= en6_next;
      lcd_typeb_reg <= lcd_typeb_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Request forwarding and interrupt
  // ---------------------------------------------------------------------------
  logic [7:0] en3_eff;
  logic [7:0] req6_next, req3_next, req4_next;
  logic [7:0] req6_reg, req3_reg, req4_reg;
  logic       irq_reg, irq_next;

  always_comb begin
    en3_eff             = en3_reg;
    en3_eff[BIT_LCD_EN] = en3_reg[BIT_LCD_EN] & lcd_typeb_reg;
    // Flags latch regardless; only enabled ones reach the core
    req6_next = flags_next & en6_reg;
    req3_next = i_src_three_req & en3_eff;
    req4_next = i_src_four_req & en4_reg & en4_mask;
    irq_next  = |req3_next || |req4_next || |req6_next;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      req6_reg <= 8'h00;
      req3_reg <= 8'h00;
      req4_reg <= 8'h00;
      irq_reg  <= 1'b0;
    end else begin
      req6_reg <= req6_next;
      req3_reg <= req3_next;
      req4_reg <= req4_next;
      irq_reg  <= irq_next;
    end
  end

  assign o_req_six   = req6_reg;
  assign o_req_three = req3_reg;
  assign o_req_four  = req4_reg;
  assign o_irq       = irq_reg;

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0;
    case (avs_address)
      OFF_FLAGS_SIX: rd_word = {24'h0, flags_reg & FLAGS_SIX_MASK};
      OFF_ENABLE_THREE: rd_word = {24'h0, en3_reg};
      OFF_ENABLE_FOUR: rd_word = {24'h0, en4_reg & en4_mask};
      OFF_IRQ_STATUS: rd_word = {24'h0, flags_reg};
      OFF_IRQ_EN_W: rd_word = {24'h0, en6_reg};
      OFF_LCD_CFG_W: rd_word = {31'h0, lcd_typeb_reg};
      default: rd_word = 32'h0;
    endcase
  end

  pif_resp_reg u_resp (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (rd_load),
    .i_data  (rd_word),
    .o_data  (avs_readdata)
  );

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_nv_sets;
    @(posedge i_clock) disable iff (i_rst) i_nv_write_done |=> flags_reg[BIT_NV_DONE];
  endproperty
  a_nv_sets: assert property (p_nv_sets) else $error("nv flag not set");

  property p_nv_holds;
    @(posedge i_clock) disable iff (i_rst)
      flags_reg[BIT_NV_DONE] && !do_write |=> flags_reg[BIT_NV_DONE];
  endproperty
  a_nv_holds: assert property (p_nv_holds) else $error("nv flag dropped");

  // Only a completion or a software write may raise the flag
  property p_nv_quiet;
    @(posedge i_clock) disable iff (i_rst)
      !flags_reg[BIT_NV_DONE] && !i_nv_write_done && !do_write |=> !flags_reg[BIT_NV_DONE];
  endproperty
  a_nv_quiet: assert property (p_nv_quiet) else $error("nv flag set without completion");

  // Same set and hold checks for each comparator flag
  for (genvar g = 0; g < 3; g++) begin : g_cmp
    property p_cmp_sets;
      @(posedge i_clock) disable iff (i_rst) i_comparator_event[g] |=> flags_reg[BIT_CMP1 + g];
    endproperty
    a_cmp_sets: assert property (p_cmp_sets) else $error("cmp flag not set");

    property p_cmp_holds;
      @(posedge i_clock) disable iff (i_rst)
        flags_reg[BIT_CMP1 + g] && !do_write |=> flags_reg[BIT_CMP1 + g];
    endproperty
    a_cmp_holds: assert property (p_cmp_holds) else $error("cmp flag dropped");
  end

  property p_unimpl_zero;
    @(posedge i_clock) disable iff (i_rst) (flags_reg & ~FLAGS_SIX_MASK) == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented flag set");

  property p_reset_zero;
    @(posedge i_clock) i_rst |=> flags_reg == 8'h00 && en3_reg == 8'h00 && en4_reg == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

  property p_en3_write;
    @(posedge i_clock) disable iff (i_rst)
      do_write && avs_address == OFF_ENABLE_THREE |=> en3_reg == $past(wbyte);
  endproperty
  a_en3_write: assert property (p_en3_write) else $error("enable three not written");

  property p_lcd_gate;
    @(posedge i_clock) disable iff (i_rst) !lcd_typeb_reg |=> !o_req_three[BIT_LCD_EN];
  endproperty
  a_lcd_gate: assert property (p_lcd_gate) else $error("lcd request leaked");

  property p_en4_write;
    @(posedge i_clock) disable iff (i_rst)
      do_write && avs_address == OFF_ENABLE_FOUR |=> en4_reg == ($past(wbyte) & en4_mask);
  endproperty
  a_en4_write: assert property (p_en4_write) else $error("enable four not written");

  property p_small_zero;
    @(posedge i_clock) disable iff (i_rst) SMALL_PROGRAM_MEMORY |-> en4_reg[7:6] == 2'b00;
  endproperty
  a_small_zero: assert property (p_small_zero) else $error("capture 10/9 enable set");

  property p_req_gate;
    @(posedge i_clock) disable iff (i_rst) ##1 o_req_four == ($past(i_src_four_req) & $past(en4_reg) & en4_mask);
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("request not gated");

  // A write before the answer edge would let software race the event logic
  property p_write_slot;
    @(posedge i_clock) disable iff (i_rst) do_write |-> !avs_waitrequest;
  endproperty
  a_write_slot: assert property (p_write_slot) else $error("write outside answer cycle");

  property p_irq_level;
    @(posedge i_clock) disable iff (i_rst) o_irq == (|o_req_six || |o_req_three || |o_req_four);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  property p_flag_gate;
    @(posedge i_clock) disable iff (i_rst) o_req_six == (flags_reg & $past(en6_reg));
  endproperty
  a_flag_gate: assert property (p_flag_gate) else $error("flag request not gated");

  c_nv:    cover property (@(posedge i_clock) i_nv_write_done ##1 flags_reg[BIT_NV_DONE]);
  c_irq:   cover property (@(posedge i_clock) $rose(o_irq));
  c_clear: cover property (@(posedge i_clock) flags_reg != 8'h00 ##[1:20] flags_reg == 8'h00);
  c_latch: cover property (@(posedge i_clock) flags_reg[BIT_NV_DONE] && !en6_reg[BIT_NV_DONE]);
  c_lcd:   cover property (@(posedge i_clock) o_req_three[BIT_LCD_EN]);
endmodule

/* verilog/pif_pkg.sv */
package pif_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte offsets, one word apart)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] OFF_FLAGS_SIX    = 6'h00;
  localparam logic [5:0] OFF_ENABLE_THREE = 6'h04;
  localparam logic [5:0] OFF_ENABLE_FOUR  = 6'h08;
  localparam logic [5:0] OFF_IRQ_STATUS   = 6'h0c;
  localparam logic [5:0] OFF_IRQ_CLR_W    = 6'h10;
  localparam logic [5:0] OFF_IRQ_EN_W     = 6'h14;
  localparam logic [5:0] OFF_LCD_CFG_W    = 6'h18;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_NV_DONE   = 4;
  localparam int BIT_CMP3      = 2;
  localparam int BIT_CMP2      = 1;
  localparam int BIT_CMP1      = 0;
  localparam int BIT_LCD_EN    = 6;
  localparam logic [7:0] FLAGS_SIX_MASK = 8'h17;
  localparam logic [7:0] ENABLE_FOUR_SMALL_MASK = 8'h3f;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_FLAGS  = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;

  typedef struct packed {
    logic       nv_write_done;
    logic [2:0] comparator;
  } pif_events_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESP = 3'b100
  } pif_bus_state_t;

endpackage

/* verilog/pif_resp_reg.sv */
`timescale 1ns/1ns
module pif_resp_reg
  import pif_pkg::*;
(
  input  wire logic        i_clock,  // Core clock
  input  wire logic        i_rst,    // Sync reset
  input  wire logic        i_load,   // Capture read data
  input  wire logic [31:0] i_data,   // Read word
  output logic      [31:0] o_data    // Registered read data
);
  logic [31:0] data_reg;
  logic [31:0] data_next;

  always_comb begin
    data_next = i_load ? i_data : data_reg;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      data_reg <= 32'h0;
    end else begin
      data_reg <= data_next;
    end
  end

  assign o_data = data_reg;
endmodule
